// ### core/data_transfer_controller.v
// Data transfer controller: descriptor fetch, data moves and completion events.
`timescale 1ns/1ps
`include "dtc_regs.vh"
module data_transfer_controller (
    input  wire        sys_clk,
    input  wire        rst,
    // Activation from the interrupt controller.
    input  wire        act_req,
    input  wire [7:0]  act_vector,
    input  wire        act_from_dmac,
    output wire        act_ack,
    // Completion events towards sources and cpu.
    output wire        clear_source_flag,
    output wire        clear_activation_enable,
    output wire        pass_source_irq,
    output reg  [7:0]  event_vector_q,
    // Software vector register.
    input  wire        swv_wr,
    input  wire [7:0]  swv_wdata,
    output wire [7:0]  swv_rdata,
    output reg         software_done_irq_q,
    // Module stop control.
    input  wire        stop_wr,
    input  wire        stop_wdata,
    output reg         controller_stop_bit_q,
    output wire        busy,
    // On-chip bus master.
    output wire        bus_req,
    output wire        bus_we,
    output wire        bus_word,
    output reg  [15:0] bus_addr,
    output reg  [15:0] bus_wdata,
    input  wire        bus_ack,
    input  wire [15:0] bus_rdata
);

    //------------------------------------------------------------
    // State encoding
    //------------------------------------------------------------
    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_VEC  = 7'h02;
    localparam [6:0] S_RD   = 7'h04;
    localparam [6:0] S_DRD  = 7'h08;
    localparam [6:0] S_DWR  = 7'h10;
    localparam [6:0] S_WB   = 7'h20;
    localparam [6:0] S_END  = 7'h40;

    reg  [6:0]  st_q;
    reg  [2:0]  idx_q;
    reg  [7:0]  vec_q;
    reg         sw_run_q;
    reg         dmac_q;
    reg  [15:0] desc_q;
    reg  [7:0]  mode_register_a;
    reg  [7:0]  mode_register_b;
    reg  [15:0] source_pointer;
    reg  [15:0] destination_pointer;
    reg  [15:0] count_register_a;
    reg  [15:0] count_register_b;
    reg  [15:0] blk_start_q;
    reg  [15:0] data_q;
    reg         end_q;
    reg         software_activate_bit;
    reg  [6:0]  swv_num_q;

    wire [7:0]  block_size_hold    = count_register_a[15:8];
    wire [7:0]  block_size_counter = count_register_a[7:0];
    wire        blk_mode = (mode_register_a[`MDA_MD] == `MD_BLOCK);
    wire        chain_enable = mode_register_b[`MDB_CHAIN];
    wire        per_transfer_irq_select = mode_register_b[`MDB_IRQSEL];
    wire        sw_pending = software_activate_bit & ~software_done_irq_q & ~sw_run_q;
    wire        fin = (st_q == S_END);
    // irq cause at end of the last descriptor
    wire        irq_cause = end_q | per_transfer_irq_select;

    // Steps a pointer by its two-bit mode and the transfer size.
    function [15:0] step_ptr;
        input [15:0] p;
        input [1:0]  m;
        input        sz;
        begin
            case (m)
                `MODE_INC: step_ptr = p + (sz ? 16'h0002 : 16'h0001);
                `MODE_DEC: step_ptr = p - (sz ? 16'h0002 : 16'h0001);
                default:   step_ptr = p;
            endcase
        end
    endfunction

    //------------------------------------------------------------
    // Handshake and event strobes
    //------------------------------------------------------------
    assign busy     = ~st_q[0];
    assign act_ack  = st_q[0] & act_req & ~controller_stop_bit_q;
    assign bus_req  = st_q[1] | st_q[2] | st_q[3] | st_q[4] | st_q[5];
    assign bus_we   = st_q[4] | st_q[5];
    assign bus_word = ~(st_q[3] | st_q[4]) | mode_register_a[`MDA_SIZE];
    // flag cleared when the count goes on and per-transfer irq select is clear
    assign clear_source_flag = fin & ~sw_run_q & ~irq_cause;
    // enable cleared at count end or with per-transfer irq select set; not for dmac activation
    assign clear_activation_enable = fin & ~sw_run_q & ~dmac_q & irq_cause;
    // source's own irq; withheld for dmac activation
    assign pass_source_irq = fin & ~sw_run_q & ~dmac_q & irq_cause;
    assign swv_rdata = {software_activate_bit, swv_num_q};

    //------------------------------------------------------------
    // Bus address and write data
    //------------------------------------------------------------
    // Drives the bus address and write data for the current state.
    always @* begin
        bus_addr  = desc_q + {12'h000, idx_q, 1'b0};
        bus_wdata = data_q;
        case (st_q)
            S_VEC: bus_addr = `VEC_BASE + {7'h00, vec_q, 1'b0};
            S_DRD: bus_addr = source_pointer;
            S_DWR: bus_addr = destination_pointer;
            S_WB: begin
                case (idx_q)
                    `IDX_SRC:  bus_wdata = source_pointer;
                    `IDX_DST:  bus_wdata = destination_pointer;
                    `IDX_CNTA: bus_wdata = count_register_a;
                    default:   bus_wdata = count_register_b;
                endcase
            end
            default: bus_addr = desc_q + {12'h000, idx_q, 1'b0};
        endcase
    end

    //------------------------------------------------------------
    // Transfer sequencer
    //------------------------------------------------------------
    // Fetches descriptors, moves data, writes back and chains.
    always @(posedge sys_clk) begin
        if (rst) begin
            st_q                <= S_IDLE;
            idx_q               <= 3'h0;
            vec_q               <= 8'h00;
            sw_run_q            <= 1'b0;
            dmac_q              <= 1'b0;
            desc_q              <= 16'h0000;
            mode_register_a     <= 8'h00;
            mode_register_b     <= 8'h00;
            source_pointer      <= 16'h0000;
            destination_pointer <= 16'h0000;
            count_register_a    <= 16'h0000;
            count_register_b    <= 16'h0000;
            blk_start_q         <= 16'h0000;
            data_q              <= 16'h0000;
            end_q               <= 1'b0;
            event_vector_q      <= 8'h00;
        end else begin
            case (st_q)
                S_IDLE: begin
                    idx_q <= 3'h0;
                    if (!controller_stop_bit_q && act_req) begin
                        vec_q    <= act_vector;
                        sw_run_q <= 1'b0;
                        dmac_q   <= act_from_dmac;
                        st_q     <= S_VEC;
                    end else if (!controller_stop_bit_q && sw_pending) begin
                        vec_q    <= {1'b0, swv_num_q};
                        sw_run_q <= 1'b1;
                        dmac_q   <= 1'b0;
                        st_q     <= S_VEC;
                    end
                end
                S_VEC: begin
                    if (bus_ack) begin
                        desc_q <= bus_rdata;
                        st_q   <= S_RD;
                    end
                end
                S_RD: begin
                    if (bus_ack) begin
                        case (idx_q)
                            `IDX_MODE: begin
                                mode_register_a <= bus_rdata[15:8];
                                mode_register_b <= bus_rdata[7:0];
                            end
                            `IDX_SRC:  source_pointer      <= bus_rdata;
                            `IDX_DST:  destination_pointer <= bus_rdata;
                            `IDX_CNTA: count_register_a    <= bus_rdata;
                            default:   count_register_b    <= bus_rdata;
                        endcase
                        if (idx_q == `IDX_CNTB) begin
                            blk_start_q <= mode_register_a[`MDA_SIDE] ? source_pointer
                                                                       : destination_pointer;
                            st_q        <= S_DRD;
                        end else begin
                            idx_q <= idx_q + 3'h1;
                        end
                    end
                end
                S_DRD: begin
                    if (bus_ack) begin
                        data_q <= bus_rdata;
                        st_q   <= S_DWR;
                    end
                end
                S_DWR: begin
                    if (bus_ack) begin
                        source_pointer      <= step_ptr(source_pointer,
                                                        mode_register_a[`MDA_SM],
                                                        mode_register_a[`MDA_SIZE]);
                        destination_pointer <= step_ptr(destination_pointer,
                                                        mode_register_a[`MDA_DM],
                                                        mode_register_a[`MDA_SIZE]);
                        idx_q <= `IDX_SRC;
                        if (!blk_mode) begin
                            // full 16-bit count in count A
                            count_register_a <= count_register_a - 16'h0001;
                            end_q            <= (count_register_a == 16'h0001);
                            st_q             <= S_WB;
                        end else if (block_size_counter == 8'h01) begin
                            // block end restores counter and block side
                            count_register_a[7:0] <= block_size_hold;
                            if (mode_register_a[`MDA_SIDE])
                                source_pointer <= blk_start_q;
                            else
                                destination_pointer <= blk_start_q;
                            count_register_b <= count_register_b - 16'h0001;
                            end_q            <= (count_register_b == 16'h0001);
                            st_q             <= S_WB;
                        end else begin
                            // low byte counts transfers in the block
                            count_register_a[7:0] <= block_size_counter - 8'h01;
                            st_q                  <= S_DRD;
                        end
                    end
                end
                S_WB: begin
                    if (bus_ack) begin
                        if (idx_q != `IDX_CNTB) begin
                            idx_q <= idx_q + 3'h1;
                        end else if (chain_enable) begin
                            desc_q <= desc_q + `DESC_STRIDE;
                            idx_q  <= `IDX_MODE;
                            st_q   <= S_RD;
                        end else begin
                            // one transfer per activation then finish
                            event_vector_q <= vec_q;
                            st_q           <= S_END;
                        end
                    end
                end
                S_END: begin
                    sw_run_q <= 1'b0;
                    st_q     <= S_IDLE;
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    //------------------------------------------------------------
    // Software vector register and done interrupt
    //------------------------------------------------------------
    // Holds the activate bit, the vector number and the done irq.
    always @(posedge sys_clk) begin
        if (rst) begin
            software_activate_bit <= 1'b0;
            swv_num_q             <= 7'h00;
            software_done_irq_q   <= 1'b0;
        end else begin
            if (swv_wr) begin
                if (!swv_wdata[`SWV_ACT]) begin
                    software_activate_bit <= 1'b0;
                    software_done_irq_q   <= 1'b0;
                    swv_num_q             <= swv_wdata[6:0];
                end else if (!software_activate_bit) begin
                    software_activate_bit <= 1'b1;
                    swv_num_q             <= swv_wdata[6:0];
                end
            end
            // done raised only at finish; never while waiting or running
            if (fin && sw_run_q) begin
                if (irq_cause) begin
                    software_activate_bit <= 1'b1;
                    software_done_irq_q   <= 1'b1;
                end else if (!(swv_wr && swv_wdata[`SWV_ACT])) begin
                    software_activate_bit <= 1'b0;
                end
            end
        end
    end

    //------------------------------------------------------------
    // Module stop
    //------------------------------------------------------------
    // Stop bit; a write of one is refused while the sequencer runs.
    always @(posedge sys_clk) begin
        if (rst) begin
            controller_stop_bit_q <= 1'b0;
        end else if (stop_wr) begin
            if (!stop_wdata)
                controller_stop_bit_q <= 1'b0;
            else if (!busy && !act_ack)
                controller_stop_bit_q <= 1'b1;
        end
    end

endmodule // data_transfer_controller

// ### core/dtc_regs.vh
// Constants shared by the data transfer controller.
// Notes on behaviour
// - Mode A holds source, destination and transfer mode plus size; zeros mean fixed/normal/byte.
// - Transfer mode 10 selects block; source mode 10 increments the source pointer.
// - Chain and per-transfer irq select both zero: one transfer per activation.
// - Normal mode: 16-bit count A holds the count; count B ignored.
// - After a normal transfer step destination per mode and decrement count A.
// - Transfer not ending the count, with per-transfer irq select clear, clears the source request flag.
// - Count end: keep flag, clear activation enable, pass the source irq on.
// - Block mode: count A high byte holds block size, low byte counts it.
// - Block mode: count B holds the number of blocks.
// - Software vector register: activate bit on top, vector number below.
// - Software transfer finishing at count end or with per-transfer irq select set raises the software done irq.
// - Irq requested on count end or when per-transfer irq select is set.
// - Interrupt activation delivers the source's own irq, still masked upstream.
// - Software activation, select set or count end: keep activate bit, raise done.
// - No software done irq while its transfer waits or runs.
// - Stop bit halts the controller; writing one is rejected while busy.
// - Dmac-end activation: no enable control and no cpu irq at count end.
// - Block end restores block counter and block-side pointer; other pointer steps.
// - Chain set: no irq, flag untouched, then run the next descriptor.
`ifndef XFR_REGS_VH
`define XFR_REGS_VH
`define VEC_BASE      16'h0400
`define DESC_STRIDE   16'h000a
`define IDX_MODE      3'h0
`define IDX_SRC       3'h1
`define IDX_DST       3'h2
`define IDX_CNTA      3'h3
`define IDX_CNTB      3'h4
`define MDA_SM        7:6
`define MDA_DM        5:4
`define MDA_MD        3:2
`define MDA_SIDE      1
`define MDA_SIZE      0
`define MDB_CHAIN     7
`define MDB_IRQSEL    6
`define MODE_INC      2'h2
`define MODE_DEC      2'h3
`define MD_BLOCK      2'h2
`define SWV_ACT       7
`endif

// ### dv/data_transfer_controller_checker.sv
// Port-level assertions for the data transfer controller.
`timescale 1ns/1ps
module data_transfer_controller_checker (
    input logic        sys_clk,
    input logic        rst,
    input logic        act_req,
    input logic [7:0]  act_vector,
    input logic        act_from_dmac,
    input logic        act_ack,
    input logic        clear_source_flag,
    input logic        clear_activation_enable,
    input logic        pass_source_irq,
    input logic        swv_wr,
    input logic [7:0]  swv_wdata,
    input logic [7:0]  swv_rdata,
    input logic        software_done_irq_q,
    input logic        stop_wr,
    input logic        stop_wdata,
    input logic        controller_stop_bit_q,
    input logic        busy,
    input logic        bus_req,
    input logic        bus_we,
    input logic [15:0] bus_addr,
    input logic        bus_ack
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_vector_fetch: assert property (act_ack |=> bus_req && !bus_we
        && bus_addr == 16'h0400 + {7'h00, $past(act_vector), 1'b0}) else $error("bad vector fetch");
    a_start_when_idle: assert property (act_ack |-> act_req && !busy
        && !controller_stop_bit_q) else $error("start taken while busy or stopped");
    a_stop_refused: assert property (stop_wr && stop_wdata && busy && !controller_stop_bit_q
        |=> !controller_stop_bit_q) else $error("stop bit set while busy");
    a_stop_taken: assert property (stop_wr && !busy && !act_ack
        |=> controller_stop_bit_q == $past(stop_wdata)) else $error("stop write lost");
    a_done_quiet: assert property ($rose(software_done_irq_q) |-> !busy && !bus_req)
        else $error("done irq raised during transfer");
    a_end_then_idle: assert property (clear_source_flag || pass_source_irq |=> !busy)
        else $error("more work after completion event");
    a_pass_clears_enable: assert property (pass_source_irq
        |-> clear_activation_enable && !clear_source_flag) else $error("count end events wrong");
    a_flag_one_pulse: assert property (clear_source_flag |=> !clear_source_flag)
        else $error("flag clear longer than one cycle");
    a_bus_request_hold: assert property (bus_req && !bus_ack
        |=> bus_req && $stable(bus_addr) && $stable(bus_we)) else $error("bus request dropped");
    a_vector_write: assert property (swv_wr && swv_wdata[7] && !swv_rdata[7]
        |=> swv_rdata == $past(swv_wdata)) else $error("software vector not stored");
    a_vector_refused: assert property (swv_wr && swv_wdata[7] && swv_rdata[7]
        |=> swv_rdata[6:0] == $past(swv_rdata[6:0])) else $error("pending vector overwritten");
    a_done_cleared: assert property (swv_wr && !swv_wdata[7] && !busy
        |=> !software_done_irq_q && !swv_rdata[7]) else $error("done irq not cleared");
    // Main scenarios reached.
    c_pass_irq: cover property (pass_source_irq);
    c_soft_done: cover property ($rose(software_done_irq_q));
    c_dmac_start: cover property (act_ack && act_from_dmac);
endmodule // data_transfer_controller_checker

bind data_transfer_controller data_transfer_controller_checker chk_i (
    .sys_clk(sys_clk), .rst(rst), .act_req(act_req), .act_vector(act_vector),
    .act_from_dmac(act_from_dmac), .act_ack(act_ack), .clear_source_flag(clear_source_flag),
    .clear_activation_enable(clear_activation_enable), .pass_source_irq(pass_source_irq),
    .swv_wr(swv_wr), .swv_wdata(swv_wdata), .swv_rdata(swv_rdata),
    .software_done_irq_q(software_done_irq_q), .stop_wr(stop_wr), .stop_wdata(stop_wdata),
    .controller_stop_bit_q(controller_stop_bit_q), .busy(busy), .bus_req(bus_req),
    .bus_we(bus_we), .bus_addr(bus_addr), .bus_ack(bus_ack));

// ### dv/bus_memory.sv
// Memory and peripheral responder on the controller's on-chip bus.
`timescale 1ns/1ps
module bus_memory (
    input  logic        sys_clk,
    input  logic        rst,
    input  logic [1:0]  wait_cycles,
    input  logic        bus_req,
    input  logic        bus_we,
    input  logic        bus_word,
    input  logic [15:0] bus_addr,
    input  logic [15:0] bus_wdata,
    output logic        bus_ack,
    output logic [15:0] bus_rdata
);
    logic [15:0] mem [0:32767];
    logic [1:0]  wait_q;
    // Bench access to the descriptor store.
    task automatic poke(input logic [15:0] a, input logic [15:0] d);
        mem[a[15:1]] = d;
    endtask
    function automatic logic [15:0] peek(input logic [15:0] a);
        return mem[a[15:1]];
    endfunction
    // store always enabled
    // Answers after the set wait; released data lines toggle so stale data never matches.
    always @(posedge sys_clk) begin
        if (rst) begin
            bus_ack   <= 1'b0;
            wait_q    <= 2'h0;
            bus_rdata <= 16'h5a5a;
        end else if (bus_req && !bus_ack && wait_q == wait_cycles) begin
            bus_ack   <= 1'b1;
            wait_q    <= 2'h0;
            bus_rdata <= bus_word ? mem[bus_addr[15:1]] : bus_addr[0] ?
                {2{mem[bus_addr[15:1]][7:0]}} : {2{mem[bus_addr[15:1]][15:8]}};
            if (bus_we && bus_word) mem[bus_addr[15:1]] <= bus_wdata;
            else if (bus_we && bus_addr[0]) mem[bus_addr[15:1]][7:0] <= bus_wdata[7:0];
            else if (bus_we) mem[bus_addr[15:1]][15:8] <= bus_wdata[7:0];
        end else begin
            if (bus_req && !bus_ack) wait_q <= wait_q + 2'h1;
            bus_ack   <= 1'b0;
            bus_rdata <= ~bus_rdata;
        end
    end
endmodule // bus_memory

// ### dv/data_transfer_controller_bench.sv
// Self-checking bench for the data transfer controller.
`timescale 1ns/1ps
module data_transfer_controller_bench;
    typedef struct {
        logic [7:0]  mode_a;
        logic [7:0]  mode_b;
        logic [15:0] count_a;
        logic        dmac;
        logic [2:0]  events;
        logic [15:0] dst_wb;
        logic [15:0] cnt_wb;
    } row_t;
    logic        sys_clk, rst, act_req, act_from_dmac, act_ack, swv_wr, stop_wr, stop_wdata;
    logic        clear_source_flag, clear_activation_enable, pass_source_irq, busy;
    logic        software_done_irq_q, controller_stop_bit_q, bus_req, bus_we, bus_word, bus_ack;
    logic [7:0]  act_vector, event_vector_q, swv_wdata, swv_rdata, v;
    logic [15:0] bus_addr, bus_wdata, bus_rdata, s;
    logic [1:0]  wait_cycles;
    logic [2:0]  ev;
    int          mismatches, checked, n;
    // Events are {flag clear, irq pass, enable clear}.
    row_t rows [8] = '{
        '{8'h20, 8'h00, 16'h0002, 1'b0, 3'h4, 16'h3001, 16'h0001},
        '{8'h20, 8'h00, 16'h0001, 1'b0, 3'h3, 16'h3001, 16'h0000},
        '{8'h20, 8'h40, 16'h0005, 1'b0, 3'h3, 16'h3001, 16'h0004},
        '{8'h20, 8'h00, 16'h0001, 1'b1, 3'h0, 16'h3001, 16'h0000},
        '{8'h20, 8'h00, 16'h0003, 1'b1, 3'h4, 16'h3001, 16'h0002},
        '{8'h20, 8'h80, 16'h0001, 1'b0, 3'h4, 16'h3001, 16'h0000},
        '{8'h30, 8'h00, 16'h0002, 1'b0, 3'h4, 16'h2fff, 16'h0001},
        '{8'h21, 8'h00, 16'h0002, 1'b0, 3'h4, 16'h3002, 16'h0001}};

    data_transfer_controller dut (.sys_clk(sys_clk), .rst(rst), .act_req(act_req),
        .act_vector(act_vector), .act_from_dmac(act_from_dmac), .act_ack(act_ack),
        .clear_source_flag(clear_source_flag), .clear_activation_enable(clear_activation_enable),
        .pass_source_irq(pass_source_irq), .event_vector_q(event_vector_q), .swv_wr(swv_wr),
        .swv_wdata(swv_wdata), .swv_rdata(swv_rdata), .software_done_irq_q(software_done_irq_q),
        .stop_wr(stop_wr), .stop_wdata(stop_wdata), .controller_stop_bit_q(controller_stop_bit_q),
        .busy(busy), .bus_req(bus_req), .bus_we(bus_we), .bus_word(bus_word), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_ack(bus_ack), .bus_rdata(bus_rdata));
    bus_memory mem_i (.sys_clk(sys_clk), .rst(rst), .wait_cycles(wait_cycles), .bus_req(bus_req),
        .bus_we(bus_we), .bus_word(bus_word), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_ack(bus_ack), .bus_rdata(bus_rdata));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic put_desc(input logic [15:0] a, input logic [7:0] ma, input logic [7:0] mb,
                            input logic [15:0] sp, input logic [15:0] dp,
                            input logic [15:0] ca, input logic [15:0] cb);
        mem_i.poke(a, {ma, mb});
        mem_i.poke(a + 16'h0002, sp);
        mem_i.poke(a + 16'h0004, dp);
        mem_i.poke(a + 16'h0006, ca);
        mem_i.poke(a + 16'h0008, cb);
    endtask
    // Raises one source's activation and holds it until it is taken.
    task automatic start_act(input logic [7:0] vec, input logic d);
        int k;
        @(posedge sys_clk);
        #2;
        act_req = 1'b1;
        act_vector = vec;
        act_from_dmac = d;
        k = 0;
        do begin
            @(negedge sys_clk);
            k++;
        end while (act_ack !== 1'b1 && k < 50);
        @(posedge sys_clk);
        #2;
        act_req = 1'b0;
    endtask
    // Collects the completion events until the controller is idle again.
    task automatic wait_idle();
        int k;
        ev = 3'h0;
        k = 0;
        do begin
            @(negedge sys_clk);
            ev |= {clear_source_flag, pass_source_irq, clear_activation_enable};
            k++;
        end while (busy !== 1'b0 && k < 3000);
    endtask
    task automatic wr_pulse(input logic sw, input logic [7:0] d);
        @(posedge sys_clk);
        #2;
        swv_wr = sw;
        stop_wr = !sw;
        swv_wdata = d;
        stop_wdata = d[0];
        @(posedge sys_clk);
        #2;
        swv_wr = 1'b0;
        stop_wr = 1'b0;
    endtask
    task automatic end_sim();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Free-running system clock.
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Watchdog against a hung handshake.
    initial begin
        #1000000;
        mismatches++;
        $display("watchdog expired");
        end_sim();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst, act_req, act_from_dmac, swv_wr, stop_wr, stop_wdata} = 6'h20;
        {act_vector, swv_wdata, wait_cycles} = 18'h0;
        repeat (5) @(posedge sys_clk);
        #2 rst = 1'b0;
        for (int i = 0; i < 8; i++) begin
            s = 16'h0800 + 16'(i) * 16'h0020;
            v = 8'h21 + 8'(i);
            wait_cycles = 2'(i % 3);
            mem_i.poke(16'h0400 + {7'h00, v, 1'b0}, s);
            put_desc(s, rows[i].mode_a, rows[i].mode_b, 16'h6000, 16'h3000, rows[i].count_a, 16'h0);
            put_desc(s + 16'h000a, 8'h20, 8'h00, 16'h6000, 16'h5000, 16'h0002, 16'h0);
            start_act(v, rows[i].dmac);
            wait_idle();
            chk("events", {13'h0, rows[i].events}, {13'h0, ev});
            chk("dest pointer", rows[i].dst_wb, mem_i.peek(s + 16'h0004));
            chk("count a", rows[i].cnt_wb, mem_i.peek(s + 16'h0006));
            if (rows[i].events != 3'h0) chk("event vector", {8'h0, v}, {8'h0, event_vector_q});
            $display("row %0d done", i);
        end
        // Software-activated block of 128 bytes, with a refused second write.
        wait_cycles = 2'h1;
        mem_i.poke(16'h04c0, 16'h0900);
        put_desc(16'h0900, 8'ha8, 8'h00, 16'h1000, 16'h2000, 16'h8080, 16'h0001);
        chk("idle activate bit", 16'h0, {15'h0, swv_rdata[7]});
        wr_pulse(1'b1, 8'he0);
        wr_pulse(1'b1, 8'he5);
        chk("vector readback", 16'h00e0, {8'h0, swv_rdata});
        wait_idle();
        chk("done irq", 16'h1, {15'h0, software_done_irq_q});
        chk("activate kept", 16'h00e0, {8'h0, swv_rdata});
        chk("block source", 16'h1080, mem_i.peek(16'h0902));
        chk("block dest", 16'h2000, mem_i.peek(16'h0904));
        chk("block count a", 16'h8080, mem_i.peek(16'h0906));
        chk("block count b", 16'h0000, mem_i.peek(16'h0908));
        wr_pulse(1'b1, 8'h00);
        chk("done cleared", 16'h0, {15'h0, software_done_irq_q});
        $display("software block done");
        // Module stop: refused while busy, blocks starts when set.
        start_act(8'h21, 1'b0);
        wr_pulse(1'b0, 8'h01);
        chk("stop while busy", 16'h0, {15'h0, controller_stop_bit_q});
        wait_idle();
        wr_pulse(1'b0, 8'h01);
        chk("stop while idle", 16'h1, {15'h0, controller_stop_bit_q});
        act_req = 1'b1;
        act_vector = 8'h22;
        n = 0;
        repeat (10) @(posedge sys_clk) #2 if (act_ack === 1'b1) n++;
        act_req = 1'b0;
        chk("start while stopped", 16'h0, 16'(n));
        wr_pulse(1'b0, 8'h00);
        start_act(8'h22, 1'b0);
        wait_idle();
        $display("module stop done");
        // Reset in mid-transfer.
        start_act(8'h23, 1'b0);
        rst = 1'b1;
        repeat (2) @(posedge sys_clk);
        #2 rst = 1'b0;
        chk("reset state", 16'h0, {busy, bus_req, software_done_irq_q, controller_stop_bit_q,
            swv_rdata, 4'h0});
        $display("reset done");
        end_sim();
    end
endmodule // data_transfer_controller_bench
